// ==== verilog/cir_irq_resp.sv ====
`include "cir_defs.svh"

// Notes on behaviour
// - urgent line outranks enabled maskable line
// - one urgent response; maskable modes 0-2
// - both lines sampled on instruction's last clock
// - urgent request never masked by software
// - urgent jumps to 0066, waiting out any bus hold
// - acknowledge needs request, enable, no bus hold
// - acknowledge fetch uses I/O strobe, not memory
// - acknowledge fetch stretched by two waits
// - mode 0 call: ack plus two reads
// - mode 1 jumps to fixed 0038
// - mode 2 fetches address at base:vector
// - pending requests held, never discarded
// - reset and mask instruction clear both enables
// - enable instruction sets both enables
// - vector/refresh loads copy shadow to parity
// - urgent accept saves primary, then clears it
// - urgent return restores primary from shadow
// - mode instructions select 0, 1, 2
module cir_irq_resp (
	input  wire logic        clk_sys_i,        // system clock, 20 MHz
	input  wire logic        rst_n_i,          // sync reset, active low
	input  wire logic        ce_i,             // clock enable, freezes all
	input  wire logic        urgent_req_n_i,   // urgent request pin
	input  wire logic        maskable_req_n_i, // shared maskable pin
	input  wire logic        bus_hold_request_n_i, // bus hold pin
	input  wire logic        instr_last_i,     // last clock of instruction
	input  wire logic [15:0] pc_i,             // address of next instr
	input  wire logic [7:0]  data_i,           // data bus in
	input  wire logic [7:0]  acc_i,            // accumulator value
	input  wire logic        enable_irq_instr_i,   // enable executed
	input  wire logic        irq_mask_instr_i,     // mask executed
	input  wire logic        return_from_urgent_instr_i, // return_from_urgent_instr
	input  wire logic        set_irq_mode_instr_i, // mode set executed
	input  wire logic [1:0]  irq_mode_sel_i,   // mode number 0..2
	input  wire logic        load_vector_base_i,   // base <- acc
	input  wire logic        load_acc_from_vector_base_i, // acc <- base
	input  wire logic        load_acc_from_refresh_i,     // acc <- refresh
	output logic             busy_o,           // sequence running, stall
	output logic [15:0]      addr_o,           // address bus out
	output logic             opcode_fetch_cycle_n_o,   // fetch marker
	output logic             io_request_strobe_n_o,    // I/O strobe
	output logic             memory_request_strobe_n_o, // memory strobe
	output logic             read_n_o,         // read strobe
	output logic             jump_valid_o,     // push pc and jump, pulse
	output logic [15:0]      jump_addr_o,      // service address
	output logic             exec_valid_o,     // run supplied byte, pulse
	output logic [7:0]       exec_byte_o,      // byte from peripheral
	output logic             pv_load_o,        // parity flag write, pulse
	output logic             pv_flag_o,        // value for parity flag
	output logic [7:0]       vector_base_o,    // vector base register
	output logic [1:0]       irq_mode_o,       // current maskable mode
	output logic             irq_enabled_o     // primary enable state
);
	localparam logic [2:0] ACK_LAST =
		`CIR_ACK_BASE_T + `CIR_ACK_WAIT_T - 3'h1;
	localparam logic [2:0] RD_LAST = `CIR_MEMRD_T - 3'h1;

	// true for a one-byte restart opcode
	function automatic logic is_restart(input logic [7:0] b);
		is_restart = ((b & `CIR_RST_MASK) == `CIR_RST_MASK);
	endfunction : is_restart

	cir_en_if en ();                  // enable flip-flop link
	cir_pkg::cir_state_t state_r;     // sequencer state
	cir_pkg::cir_mode_t  mode_r;      // maskable response mode
	logic [2:0]  tcnt_r;              // clock within bus cycle
	logic [7:0]  lo_r;                // low byte of fetched address
	logic        urg_lvl;             // synced urgent pin
	logic        msk_lvl;             // synced maskable pin
	logic        hold_lvl;            // synced bus hold pin
	logic        urg_prev_r;          // urgent level one clock ago
	logic        urg_pend_r;          // urgent edge waiting for service
	logic        ei_block_r;          // enable was the last instruction
	logic        boundary;            // sample point
	logic        urg_take;            // accept urgent now
	logic        msk_take;            // accept maskable now
	logic        urg_edge;            // falling edge on urgent pin

	// pins come from outside the clock domain
	cir_sync #(.RST_VAL(1'b1)) u_sync_urg (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.pin_i     (urgent_req_n_i),
		.level_o   (urg_lvl)
	);
	cir_sync #(.RST_VAL(1'b1)) u_sync_msk (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.pin_i     (maskable_req_n_i),   // wired-OR
		.level_o   (msk_lvl)
	);
	cir_sync #(.RST_VAL(1'b1)) u_sync_hold (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.pin_i     (bus_hold_request_n_i),
		.level_o   (hold_lvl)
	);

	cir_enable_ff u_enable (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.ce_i      (ce_i),
		.en        (en.ff)
	);

	// acceptance: urgent first and unmaskable, maskable needs enable,
	// both wait while the bus is held so nothing is lost meanwhile
	always_comb begin
		urg_edge = urg_prev_r && !urg_lvl;
		boundary = instr_last_i && (state_r == cir_pkg::ST_IDLE)
			&& hold_lvl;
		urg_take = boundary && urg_pend_r;
		msk_take = boundary && !urg_pend_r && !msk_lvl
			&& en.en_primary && !ei_block_r
			&& !enable_irq_instr_i;
	end

	// instruction strobes and accepts to the enable flip-flops
	always_comb begin
		en.ei      = enable_irq_instr_i && instr_last_i;
		en.di      = irq_mask_instr_i && instr_last_i;
		en.return_from_urgent_instr    = return_from_urgent_instr_i && instr_last_i;
		en.urg_acc = ce_i && urg_take;
		en.msk_acc = ce_i && msk_take;
	end

	// urgent edge latch; a new edge wins over the service clear
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			urg_prev_r <= 1'b1;
			urg_pend_r <= 1'b0;
		end else if (ce_i) begin
			urg_prev_r <= urg_lvl;
			if (urg_edge) begin
				urg_pend_r <= 1'b1;
			end else if (urg_take) begin
				urg_pend_r <= 1'b0;
			end
		end
	end

	// enable delay: blocks through the instruction after the enable
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ei_block_r <= 1'b0;
		end else if (ce_i && instr_last_i) begin
			ei_block_r <= enable_irq_instr_i;
		end
	end

	// mode and vector base registers
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mode_r   <= cir_pkg::CIR_MODE0;
			vector_base_o <= `CIR_VBASE_RST;
		end else if (ce_i && instr_last_i) begin
			// code 3 is not a mode: keep the current one
			if (set_irq_mode_instr_i && (irq_mode_sel_i != 2'h3)) begin
				mode_r <= cir_pkg::cir_mode_t'(irq_mode_sel_i);
			end
			if (load_vector_base_i) begin
				vector_base_o <= acc_i;
			end
		end
	end

	// shadow enable into parity on the two special accumulator loads
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pv_load_o <= 1'b0;
			pv_flag_o <= 1'b0;
		end else if (ce_i) begin
			pv_load_o <= instr_last_i && (load_acc_from_vector_base_i
				|| load_acc_from_refresh_i);
			pv_flag_o <= en.en_shadow;
		end
	end

	// response sequencer: acknowledge fetch, then optional two reads
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_r      <= cir_pkg::ST_IDLE;
			tcnt_r       <= 3'h0;
			addr_o       <= 16'h0000;
			lo_r         <= 8'h00;
			jump_valid_o <= 1'b0;
			jump_addr_o  <= 16'h0000;
			exec_valid_o <= 1'b0;
			exec_byte_o  <= 8'h00;
		end else if (ce_i) begin
			jump_valid_o <= 1'b0;
			exec_valid_o <= 1'b0;
			tcnt_r       <= tcnt_r + 3'h1;
			case (state_r)
				cir_pkg::ST_IDLE: begin
					tcnt_r <= 3'h0;
					if (urg_take) begin
						// no bus cycle: straight to the fixed restart
						jump_valid_o <= 1'b1;
						jump_addr_o  <= `CIR_URGENT_ADDR;
					end else if (msk_take) begin
						state_r <= cir_pkg::ST_ACK;
						addr_o  <= pc_i;
					end
				end
				cir_pkg::ST_ACK: begin
					if (tcnt_r == ACK_LAST) begin
						tcnt_r <= 3'h0;
						state_r <= cir_pkg::ST_IDLE;
						case (mode_r)
							cir_pkg::CIR_MODE0: begin
								if (data_i == `CIR_CALL_OP) begin
									state_r <= cir_pkg::ST_RD_LO;
									addr_o  <= pc_i;
								end else if (is_restart(data_i)) begin
									jump_valid_o <= 1'b1;
									jump_addr_o  <= {10'h000,
										data_i[5:3], 3'h0};
								end else begin
									exec_valid_o <= 1'b1;
									exec_byte_o  <= data_i;
								end
							end
							cir_pkg::CIR_MODE1: begin
								jump_valid_o <= 1'b1;
								jump_addr_o  <= `CIR_MODE1_ADDR;
							end
							default: begin
								// vector used as given; bit 0 is the
								// peripheral's duty
								state_r <= cir_pkg::ST_RD_LO;
								addr_o  <= {vector_base_o, data_i};
							end
						endcase
					end
				end
				cir_pkg::ST_RD_LO: begin
					if (tcnt_r == RD_LAST) begin
						tcnt_r  <= 3'h0;
						lo_r    <= data_i;
						addr_o  <= addr_o + 16'h0001;
						state_r <= cir_pkg::ST_RD_HI;
					end
				end
				default: begin
					if (tcnt_r == RD_LAST) begin
						tcnt_r       <= 3'h0;
						state_r      <= cir_pkg::ST_IDLE;
						jump_valid_o <= 1'b1;
						jump_addr_o  <= {data_i, lo_r};
					end
				end
			endcase
		end
	end

	// bus strobes follow the state; the acknowledge fetch raises the
	// I/O strobe instead of the memory strobe
	always_comb begin
		busy_o = (state_r != cir_pkg::ST_IDLE);
		opcode_fetch_cycle_n_o = (state_r != cir_pkg::ST_ACK);
		io_request_strobe_n_o  = (state_r != cir_pkg::ST_ACK);
		memory_request_strobe_n_o = !((state_r == cir_pkg::ST_RD_LO)
			|| (state_r == cir_pkg::ST_RD_HI));
		read_n_o      = memory_request_strobe_n_o;
		irq_mode_o    = mode_r;
		irq_enabled_o = en.en_primary;
	end

	property p_urg_jump;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		urg_take |=> jump_valid_o && (jump_addr_o == `CIR_URGENT_ADDR);
	endproperty
	a_urg_jump: assert property (p_urg_jump)
		else $error("urgent accept did not jump to its restart");

	property p_ack_len;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		msk_take |=> (!io_request_strobe_n_o && memory_request_strobe_n_o)
			[*5] ##1 io_request_strobe_n_o;
	endproperty
	a_ack_len: assert property (p_ack_len)
		else $error("acknowledge fetch length or strobe wrong");

	property p_mode1;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		(msk_take && mode_r == cir_pkg::CIR_MODE1) |=> ##5
			jump_valid_o && (jump_addr_o == `CIR_MODE1_ADDR);
	endproperty
	a_mode1: assert property (p_mode1)
		else $error("mode 1 did not jump to its restart");

	property p_rd_len;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		$rose(state_r == cir_pkg::ST_RD_LO) |->
			(!memory_request_strobe_n_o)[*6] ##1 jump_valid_o;
	endproperty
	a_rd_len: assert property (p_rd_len)
		else $error("two memory reads not followed by the jump");

	property p_masked;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		(boundary && !en.en_primary) |=> !$rose(busy_o);
	endproperty
	a_masked: assert property (p_masked)
		else $error("maskable request taken while disabled");

	property p_parity;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		(instr_last_i && load_acc_from_refresh_i)
			|=> pv_load_o && (pv_flag_o == $past(en.en_shadow));
	endproperty
	a_parity: assert property (p_parity)
		else $error("parity flag not loaded from shadow enable");

endmodule : cir_irq_resp

// ==== verilog/cir_defs.svh ====
`ifndef CIR_DEFS_SVH
`define CIR_DEFS_SVH

// fixed restart targets
`define CIR_URGENT_ADDR  16'h0066
`define CIR_MODE1_ADDR   16'h0038

// acknowledge fetch: base clocks plus automatic wait states
`define CIR_ACK_BASE_T   3'h3
`define CIR_ACK_WAIT_T   3'h2
// plain memory read length in clocks
`define CIR_MEMRD_T      3'h3

// opcode patterns seen in mode 0
`define CIR_CALL_OP      8'hCD
`define CIR_RST_MASK     8'hC7
`define CIR_RST_POS      3

// reset values
`define CIR_VBASE_RST    8'h00

`endif

// ==== verilog/cir_pkg.sv ====
package cir_pkg;

	// maskable response modes, in numeric order 0, 1, 2
	typedef enum logic [1:0] {
		CIR_MODE0,
		CIR_MODE1,
		CIR_MODE2
	} cir_mode_t;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACK,
		ST_RD_LO,
		ST_RD_HI
	} cir_state_t;

endpackage : cir_pkg

// ==== verilog/cir_en_if.sv ====
// enable flip-flop commands and their state, main to flip-flop module
interface cir_en_if;
	logic ei;          // enable instruction executed
	logic di;          // mask instruction executed
	logic return_from_urgent_instr;        // return from urgent service
	logic urg_acc;     // urgent request accepted
	logic msk_acc;     // maskable request accepted
	logic en_primary;  // primary enable flip-flop
	logic en_shadow;   // shadow enable flip-flop

	modport ctl (
		output ei, di, return_from_urgent_instr, urg_acc, msk_acc,
		input  en_primary, en_shadow
	);
	modport ff (
		input  ei, di, return_from_urgent_instr, urg_acc, msk_acc,
		output en_primary, en_shadow
	);
endinterface : cir_en_if

// ==== verilog/cir_sync.sv ====
// three-stage pin synchroniser; output moves once stages two and three agree
module cir_sync #(
	parameter logic RST_VAL = 1'b1  // idle level of the pin
) (
	input  wire logic clk_sys_i,  // system clock
	input  wire logic rst_n_i,    // synchronous reset, active low
	input  wire logic ce_i,       // clock enable
	input  wire logic pin_i,      // asynchronous pin
	output logic      level_o     // filtered, synchronous level
);
	logic s1_r;  // first stage, read only by s2_r
	logic s2_r;  // second stage
	logic s3_r;  // third stage

	// shift chain
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else if (ce_i) begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// agreement filter rejects a single-clock glitch past the chain
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			level_o <= RST_VAL;
		end else if (ce_i && (s2_r == s3_r)) begin
			level_o <= s3_r;
		end
	end

	property p_sync_agree;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		(s2_r == s3_r) |=> (level_o == $past(s3_r));
	endproperty
	a_sync_agree: assert property (p_sync_agree)
		else $error("synchroniser output ignored agreeing stages");

endmodule : cir_sync

// ==== verilog/cir_enable_ff.sv ====
// primary and shadow maskable-enable flip-flops
module cir_enable_ff (
	input  wire logic clk_sys_i,  // system clock
	input  wire logic rst_n_i,    // synchronous reset, active low
	input  wire logic ce_i,       // clock enable
	cir_en_if.ff      en          // commands in, state out
);
	// primary: reset and mask clear, enable sets, return_from_urgent_instr restores,
	// any accepted request disables further maskable service
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			en.en_primary <= 1'b0;
		end else if (ce_i) begin
			if (en.urg_acc || en.msk_acc) begin
				en.en_primary <= 1'b0;
			end else if (en.di) begin
				en.en_primary <= 1'b0;
			end else if (en.ei) begin
				en.en_primary <= 1'b1;
			end else if (en.return_from_urgent_instr) begin
				en.en_primary <= en.en_shadow;
			end
		end
	end

	// shadow: keeps the pre-urgent state so return_from_urgent_instr can put it back
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			en.en_shadow <= 1'b0;
		end else if (ce_i) begin
			if (en.urg_acc) begin
				en.en_shadow <= en.en_primary;
			end else if (en.msk_acc || en.di) begin
				en.en_shadow <= 1'b0;
			end else if (en.ei) begin
				en.en_shadow <= 1'b1;
			end
		end
	end

	property p_en_set;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		(en.ei && !en.urg_acc && !en.msk_acc && !en.di)
			|=> en.en_primary && en.en_shadow;
	endproperty
	a_en_set: assert property (p_en_set)
		else $error("enable instruction did not set both flip-flops");

	property p_en_clear;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		(en.di && !en.urg_acc) |=> !en.en_primary && !en.en_shadow;
	endproperty
	a_en_clear: assert property (p_en_clear)
		else $error("mask instruction did not clear both flip-flops");

	property p_urg_copy;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		en.urg_acc |=> !en.en_primary
			&& (en.en_shadow == $past(en.en_primary));
	endproperty
	a_urg_copy: assert property (p_urg_copy)
		else $error("urgent accept did not save and clear enable");

	property p_return_from_urgent_instr;
		@(posedge clk_sys_i) disable iff (!rst_n_i || !ce_i)
		(en.return_from_urgent_instr && !en.ei && !en.di && !en.urg_acc && !en.msk_acc)
			|=> en.en_primary == $past(en.en_shadow);
	endproperty
	a_return_from_urgent_instr: assert property (p_return_from_urgent_instr)
		else $error("return did not restore primary enable");

endmodule : cir_enable_ff

// ==== tb/cir_periph.sv ====
// one interrupting peripheral on the priority chain; behavioural
module cir_periph (
	input  wire logic       clk_sys_i,          // system clock
	input  wire logic       rst_n_i,            // sync reset, active low
	input  wire logic       raise_i,            // start a request, pulse
	input  wire logic       done_i,             // service finished, pulse
	input  wire logic       ack_n_i,            // acknowledge fetch, low
	input  wire logic [7:0] resp_i,             // byte handed out on ack
	input  wire logic       chain_enable_in_i,  // higher devices idle
	output logic            chain_enable_out_o, // lower devices allowed
	output logic            req_n_o,            // open-drain request
	output logic            drive_o,            // data bus driven
	output logic [7:0]      data_o              // data bus value
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pend_r; // waiting for acknowledge
	logic serv_r; // acknowledged, service still running
	// request and service state
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pend_r <= 1'b0;
			serv_r <= 1'b0;
		end else begin
			if (raise_i) begin
				pend_r <= 1'b1;
			end else if (!ack_n_i && chain_enable_in_i && pend_r) begin
				pend_r <= 1'b0;
				serv_r <= 1'b1;
			end
			if (done_i) begin
				serv_r <= 1'b0;
			end
		end
	end
	// a blocked device neither pulls the line nor answers
	assign req_n_o = ~(pend_r & chain_enable_in_i);
	// chain stays shut until service ends
	assign chain_enable_out_o = chain_enable_in_i & ~pend_r & ~serv_r;
	assign drive_o = ~ack_n_i & chain_enable_in_i & (pend_r | serv_r);
	// bench supplies even vectors only
	assign data_o = resp_i;
endmodule : cir_periph

// ==== tb/cir_irq_resp_tb.sv ====
`define CHK(a, b, m) begin \
	compares++; \
	if ((a) !== (b)) begin \
		fail_count++; \
		$display("BAD %0t %s", $time, m); \
	end \
end

module cir_irq_resp_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [6:0] EI = 7'h40; // enable instruction
	localparam logic [6:0] DI = 7'h20; // mask instruction
	localparam logic [6:0] RT = 7'h10; // return from urgent service
	localparam logic [6:0] IM = 7'h08; // set maskable mode
	localparam logic [6:0] VB = 7'h04; // load vector base
	localparam logic [6:0] LI = 7'h02; // acc from vector base
	localparam logic [6:0] LR = 7'h01; // acc from refresh
	localparam logic [6:0] NO = 7'h00; // any other instruction
	logic        clk, rst_n, ce, urg_n, hold_n, last; // clock, reset, pins
	logic [6:0]  s;                // strobes in EI..LR order
	logic [1:0]  msel, raise, done; // mode number, peripheral controls
	logic [7:0]  acc, r0, r1, d0, d1, data;
	logic [7:0]  data_q = 8'h00;   // last bus value
	logic        busy, m1n, ion, mrn, rdn, jv, xv, xe, pvl, pvf, en;
	logic        q0, q1, e0, e1, ceo0;
	logic [15:0] addr, ja, ex [5];
	logic [7:0]  vb, xb;
	logic [1:0]  md;
	logic [1:0]  mv [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2}; // modes in turn
	logic [7:0]  by [5] = '{8'hEF, 8'h5A, 8'hCD, 8'h00, 8'h34}; // answers
	int          fail_count, compares, ack_len, ack_last, ack_cnt, n;

	// memory contents as a fixed function of the address
	function automatic logic [7:0] mem(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'hA5;
	endfunction : mem
	// service address stored low byte first at p
	function automatic logic [15:0] tgt(input logic [15:0] p);
		return {mem(p + 16'h0001), mem(p)};
	endfunction : tgt

	// released bus shows the inverse so a stale byte never passes
	assign data = e0 ? d0 : e1 ? d1 : (!mrn && !rdn) ? mem(addr) : ~data_q;
	always @(posedge clk) data_q <= data;

	cir_irq_resp DUT (
		.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce),
		.urgent_req_n_i(urg_n), .maskable_req_n_i(q0 & q1),
		.bus_hold_request_n_i(hold_n), .instr_last_i(last),
		.pc_i(16'h4000), .data_i(data), .acc_i(acc),
		.enable_irq_instr_i(s[6]), .irq_mask_instr_i(s[5]),
		.return_from_urgent_instr_i(s[4]), .set_irq_mode_instr_i(s[3]),
		.irq_mode_sel_i(msel), .load_vector_base_i(s[2]),
		.load_acc_from_vector_base_i(s[1]), .load_acc_from_refresh_i(s[0]),
		.busy_o(busy), .addr_o(addr), .opcode_fetch_cycle_n_o(m1n),
		.io_request_strobe_n_o(ion), .memory_request_strobe_n_o(mrn),
		.read_n_o(rdn), .jump_valid_o(jv), .jump_addr_o(ja),
		.exec_valid_o(xv), .exec_byte_o(xb), .pv_load_o(pvl), .pv_flag_o(pvf),
		.vector_base_o(vb), .irq_mode_o(md), .irq_enabled_o(en));
	cir_periph P0 (
		.clk_sys_i(clk), .rst_n_i(rst_n), .raise_i(raise[0]),
		.done_i(done[0]), .ack_n_i(ion | m1n), .resp_i(r0),
		.chain_enable_in_i(1'b1), .chain_enable_out_o(ceo0),
		.req_n_o(q0), .drive_o(e0), .data_o(d0));
	cir_periph P1 (
		.clk_sys_i(clk), .rst_n_i(rst_n), .raise_i(raise[1]),
		.done_i(done[1]), .ack_n_i(ion | m1n), .resp_i(r1),
		.chain_enable_in_i(ceo0), .chain_enable_out_o(),
		.req_n_o(q1), .drive_o(e1), .data_o(d1));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ack length and strobe mix, sampled at the falling edge where the
	// combinational strobes are settled, never in the launching step
	always @(negedge clk) begin
		if (!ion) begin
			ack_len++;
			`CHK({mrn, m1n}, 2'h2, "ack strobes")
		end else if (ack_len != 0) begin
			ack_last = ack_len;
			ack_len = 0;
			ack_cnt++;
		end
	end

	task automatic final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	task automatic tmo(input string m);
		fail_count++;
		$display("BAD %0t wait ran out: %s", $time, m);
		final_report();
	endtask : tmo

	// one instruction's last clock; core never raises it while stalled
	task automatic bnd(input logic [6:0] st, input logic [1:0] ms);
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 50) begin
			k++;
			@(negedge clk);
		end
		if (k == 50) tmo("busy");
		last = 1'b1;
		s = st;
		msel = ms;
		@(negedge clk);
		last = 1'b0;
		s = NO;
	endtask : bnd

	// wait for the jump or execute pulse, then compare kind and value;
	// xe says an executed byte rather than a jump is expected
	task automatic jmp(input logic [15:0] a, input string m);
		int k;
		k = 0;
		while ((jv | xv) !== 1'b1 && k < 40) begin
			k++;
			@(negedge clk);
		end
		if (k == 40) tmo(m);
		`CHK({xv, xv ? {8'h00, xb} : ja}, {xe, a}, m)
		@(negedge clk);
	endtask : jmp

	// neither jump nor acknowledge for a while
	task automatic quiet(input string m);
		repeat (10) begin
			`CHK(jv | ~ion, 1'b0, m)
			@(negedge clk);
		end
	endtask : quiet

	// peripheral pulses, then time for the pin synchroniser
	task automatic kick(input logic [1:0] rw, input logic [1:0] dw);
		raise = rw;
		done = dw;
		@(negedge clk);
		raise = 2'h0;
		done = 2'h0;
		repeat (5) @(negedge clk);
	endtask : kick

	task automatic urg;
		urg_n = 1'b0;
		repeat (4) @(negedge clk);
		urg_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask : urg

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		xe = 1'b0;
		urg_n = 1'b1;
		hold_n = 1'b1;
		last = 1'b0;
		s = NO;
		msel = 2'h0;
		acc = 8'h00;
		raise = 2'h0;
		done = 2'h0;
		r0 = 8'hEF;
		r1 = 8'h56;
		ex = '{16'h0028, 16'h005A, tgt(16'h4000), 16'h0038, tgt(16'h1234)};
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		`CHK(md, 2'h0, "mode at reset")
		`CHK(vb, 8'h00, "base at reset")
		`CHK(en, 1'b0, "enable at reset")
		`CHK({busy, ion, mrn, m1n}, 4'h7, "idle at reset")
		$display("end reset");
		// urgent request while maskable ones are off
		urg();
		bnd(NO, 2'h0);
		jmp(16'h0066, "urgent while masked");
		bnd(LR, 2'h0);
		`CHK({pvl, pvf}, 2'h2, "shadow after urgent")
		$display("end urgent masked");
		// bus hold defers both; urgent outranks maskable
		bnd(EI, 2'h0);
		`CHK(en, 1'b1, "enable set")
		bnd(LI, 2'h0);
		`CHK({pvl, pvf}, 2'h3, "shadow set")
		hold_n = 1'b0;
		urg();
		kick(2'h1, 2'h0);
		bnd(NO, 2'h0);
		quiet("bus held");
		hold_n = 1'b1;
		repeat (4) @(negedge clk);
		n = ack_cnt;
		bnd(NO, 2'h0);
		jmp(16'h0066, "urgent first");
		`CHK(ack_cnt, n, "no ack for urgent")
		`CHK(en, 1'b0, "primary cleared")
		bnd(LR, 2'h0);
		`CHK({pvl, pvf}, 2'h3, "shadow kept")
		bnd(RT, 2'h0);
		`CHK(en, 1'b1, "primary restored")
		bnd(NO, 2'h0);
		jmp(16'h0028, "restart byte");
		kick(2'h0, 2'h1);
		bnd(EI, 2'h0);
		bnd(DI, 2'h0);
		`CHK(en, 1'b0, "mask instruction")
		bnd(LI, 2'h0);
		`CHK({pvl, pvf}, 2'h2, "shadow cleared")
		$display("end priority");
		// masked request waits; enable acts one instruction late
		kick(2'h1, 2'h0);
		bnd(NO, 2'h0);
		quiet("masked");
		bnd(EI, 2'h0);
		bnd(NO, 2'h0);
		quiet("just after enable");
		bnd(NO, 2'h0);
		jmp(16'h0028, "pending served");
		kick(2'h0, 2'h1);
		$display("end masked");
		// every maskable mode, mode 0 restart, plain byte and call
		acc = 8'h12;
		bnd(VB, 2'h0);
		`CHK(vb, 8'h12, "vector base")
		for (int i = 0; i < 5; i++) begin
			r0 = by[i];
			xe = (i == 1);
			bnd(IM, mv[i]);
			`CHK(md, mv[i], "mode select")
			bnd(EI, 2'h0);
			bnd(NO, 2'h0);
			kick(2'h1, 2'h0);
			bnd(NO, 2'h0);
			if (i == 4) begin
				ce = 1'b0; // three frozen clocks stretch the acknowledge
				repeat (3) @(negedge clk);
				ce = 1'b1;
			end
			jmp(ex[i], "maskable target");
			`CHK(ack_last, (i == 4) ? 8 : 5, "ack length")
			kick(2'h0, 2'h1);
		end
		bnd(IM, 2'h3);
		`CHK(md, 2'h2, "mode code 3 ignored")
		$display("end modes");
		// two chained devices ask together in mode 2
		bnd(EI, 2'h0);
		bnd(NO, 2'h0);
		kick(2'h3, 2'h0);
		bnd(NO, 2'h0);
		jmp(tgt(16'h1234), "first in chain");
		kick(2'h0, 2'h1);
		bnd(EI, 2'h0);
		bnd(NO, 2'h0);
		bnd(NO, 2'h0);
		jmp(tgt(16'h1256), "second in chain");
		kick(2'h0, 2'h2);
		$display("end chain");
		final_report();
	end
endmodule : cir_irq_resp_tb
